// >>> dif_pkg.sv
/*
  Constants and state type for the dual-interface EEPROM serial slave front end.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dif_pkg;
  // Device select byte layout
  localparam logic [3:0] DIF_DEV_TYPE = 4'hA;
  localparam int DIF_TYPE_MSB = 7;
  localparam int DIF_TYPE_LSB = 4;
  localparam int DIF_AREA_BIT = 3;
  localparam int DIF_STRAP_HI_BIT = 2;
  localparam int DIF_STRAP_LO_BIT = 1;
  localparam int DIF_RW_BIT = 0;
  // Byte and address sizes
  localparam int DIF_BYTE_W = 8;
  localparam logic [3:0] DIF_BITS_PER_BYTE = 4'h8;
  localparam int DIF_ADDR_W = 16;
  localparam int DIF_MEM_BYTES = 8192;
  localparam int DIF_MEM_AW = 13;
  localparam int DIF_MEM_WORDS = 2048;
  localparam int DIF_WORD_AW = 11;
  localparam int DIF_WORD_LSB = 2;
  // Reset values
  localparam logic [15:0] DIF_ADDR_RST = 16'h0000;
  localparam logic [7:0] DIF_BYTE_RST = 8'h00;

  typedef enum logic [3:0] {
    DIF_IDLE,
    DIF_DEVSEL,
    DIF_ACK_DEV,
    DIF_ADDR_HI,
    DIF_ACK_HI,
    DIF_ADDR_LO,
    DIF_ACK_LO,
    DIF_WDATA,
    DIF_ACK_WD,
    DIF_RDATA,
    DIF_MACK,
    DIF_WAIT_WR,
    DIF_IGNORE
  } dif_state_t;
endpackage

// >>> dif_i2c_slave.sv
/*
  Two-wire serial slave front end of a dual-interface EEPROM: framing, device
  select, two-byte address, acknowledge, byte read/write strobes to the array.
  Assumes scl_i and sda_i are already synchronous to clk, the array answers a
  read strobe by the next clk cycle and holds mem_rd_data, and rst_n is the
  power-on reset.
*/
`timescale 1ns/10ps
module dif_i2c_slave
  import dif_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Strap inputs
  input wire logic strap_addr_lo,
  input wire logic strap_addr_hi,
  // Memory array side
  output logic [dif_pkg::DIF_MEM_AW-1:0] mem_addr,
  output logic [dif_pkg::DIF_WORD_AW-1:0] mem_word_idx,
  output logic area_select_bit,
  output logic mem_wr,
  output logic [dif_pkg::DIF_BYTE_W-1:0] mem_wr_data,
  output logic mem_rd,
  input wire logic [dif_pkg::DIF_BYTE_W-1:0] mem_rd_data,
  input wire logic mem_busy,
  // Status
  output logic standby
);
  import dif_pkg::*;

  dif_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [15:0] addr_q, addr_d;
  logic rw_q, rw_d;
  logic area_q, area_d;
  logic oe_q, oe_d;
  logic wr_q, wr_d;
  logic [7:0] wdat_q, wdat_d;
  logic rd_q, rd_d;
  logic scl_q, sda_q;
  logic [1:0] strap_q, strap_d;
  logic stby_q, stby_d;

  logic scl_rise, scl_fall, start_c, stop_c, dev_match, byte_full;

  // Bus events seen at clk rate
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_c = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
  assign byte_full = (cnt_q == DIF_BITS_PER_BYTE);
  assign dev_match = (sh_q[DIF_TYPE_MSB:DIF_TYPE_LSB] == DIF_DEV_TYPE)
    && (sh_q[DIF_STRAP_HI_BIT] == strap_q[1])
    && (sh_q[DIF_STRAP_LO_BIT] == strap_q[0]);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    addr_d = addr_q;
    rw_d = rw_q;
    area_d = area_q;
    oe_d = oe_q;
    wr_d = 1'b0;
    wdat_d = wdat_q;
    rd_d = 1'b0;
    // Pad pull-downs make floating straps read 0
    strap_d = {strap_addr_hi, strap_addr_lo};
    if (start_c) begin
      state_d = DIF_DEVSEL;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      oe_d = 1'b0;
      state_d = mem_busy ? DIF_WAIT_WR : DIF_IDLE;
    end else begin
      unique case (state_q)
        DIF_IDLE, DIF_IGNORE: begin
        end
        DIF_WAIT_WR: begin
          if (!mem_busy) begin
            state_d = DIF_IDLE;
          end
        end
        DIF_DEVSEL, DIF_ADDR_HI, DIF_ADDR_LO, DIF_WDATA: begin
          if (scl_rise && !byte_full) begin
            sh_d = {sh_q[6:0], sda_i};
            cnt_d = cnt_q + 4'h1;
          end
          if (scl_fall && byte_full) begin
            oe_d = 1'b1;
            unique case (state_q)
              DIF_DEVSEL: begin
                if (dev_match) begin
                  rw_d = sh_q[DIF_RW_BIT];
                  area_d = sh_q[DIF_AREA_BIT];
                  state_d = DIF_ACK_DEV;
                end else begin
                  oe_d = 1'b0;
                  state_d = DIF_IGNORE;
                end
              end
              DIF_ADDR_HI: begin
                addr_d[15:8] = sh_q;
                state_d = DIF_ACK_HI;
              end
              DIF_ADDR_LO: begin
                addr_d[7:0] = sh_q;
                state_d = DIF_ACK_LO;
              end
              default: begin
                wr_d = 1'b1;
                wdat_d = sh_q;
                state_d = DIF_ACK_WD;
              end
            endcase
          end
        end
        DIF_ACK_HI, DIF_ACK_LO, DIF_ACK_WD: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            cnt_d = 4'h0;
            if (state_q == DIF_ACK_HI) begin
              state_d = DIF_ADDR_LO;
            end else begin
              state_d = DIF_WDATA;
            end
            if (state_q == DIF_ACK_WD) begin
              addr_d = addr_q + 16'h0001;
            end
          end
        end
        DIF_ACK_DEV, DIF_MACK: begin
          if (scl_rise) begin
            if (state_q == DIF_ACK_DEV) begin
              rd_d = rw_q;
            end else if (!sda_i) begin
              rd_d = 1'b1;
            end else begin
              state_d = DIF_IGNORE;
            end
          end
          if (scl_fall) begin
            cnt_d = 4'h0;
            if (state_q == DIF_ACK_DEV && !rw_q) begin
              oe_d = 1'b0;
              state_d = DIF_ADDR_HI;
            end else begin
              // First data bit goes out on this falling edge
              oe_d = ~mem_rd_data[7];
              tx_d = {mem_rd_data[6:0], 1'b0};
              cnt_d = 4'h1;
              addr_d = addr_q + 16'h0001;
              state_d = DIF_RDATA;
            end
          end
        end
        DIF_RDATA: begin
          if (scl_fall) begin
            if (!byte_full) begin
              oe_d = ~tx_q[7];
              tx_d = {tx_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end else begin
              oe_d = 1'b0;
              state_d = DIF_MACK;
            end
          end
        end
      endcase
    end
    stby_d = (state_d == DIF_IDLE);
  end

  // Async reset doubles as power-on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DIF_IDLE;
      cnt_q <= 4'h0;
      sh_q <= DIF_BYTE_RST;
      tx_q <= DIF_BYTE_RST;
      addr_q <= DIF_ADDR_RST;
      rw_q <= 1'b0;
      area_q <= 1'b0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
      wdat_q <= DIF_BYTE_RST;
      rd_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      strap_q <= 2'h0;
      stby_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      addr_q <= addr_d;
      rw_q <= rw_d;
      area_q <= area_d;
      oe_q <= oe_d;
      wr_q <= wr_d;
      wdat_q <= wdat_d;
      rd_q <= rd_d;
      scl_q <= scl_i;
      sda_q <= sda_i;
      strap_q <= strap_d;
      stby_q <= stby_d;
    end
  end

  // Open-drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign mem_addr = addr_q[DIF_MEM_AW-1:0];
  assign mem_word_idx = addr_q[DIF_MEM_AW-1:DIF_WORD_LSB];
  assign area_select_bit = area_q;
  assign mem_wr = wr_q;
  assign mem_wr_data = wdat_q;
  assign mem_rd = rd_q;
  assign standby = stby_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Protocol checks
  oe_only_ack_a: assert property (oe_q |-> state_q inside {DIF_ACK_DEV, DIF_ACK_HI,
    DIF_ACK_LO, DIF_ACK_WD, DIF_RDATA})
    else $error("data line pulled outside ack or read");
  nomatch_ignore_a: assert property (state_q == DIF_DEVSEL && !start_c && !stop_c
    && scl_fall && byte_full && !dev_match |=> state_q == DIF_IGNORE && !oe_q)
    else $error("mismatched select not ignored");
  match_ack_a: assert property (state_q == DIF_DEVSEL && !start_c && !stop_c
    && scl_fall && byte_full && dev_match |=> state_q == DIF_ACK_DEV && oe_q)
    else $error("matching select not acknowledged");
  start_devsel_a: assert property (start_c
    |=> state_q == DIF_DEVSEL && cnt_q == 4'h0)
    else $error("start not decoded");
  stop_idle_a: assert property (stop_c && !start_c && !mem_busy
    |=> state_q == DIF_IDLE ##1 standby)
    else $error("stop did not reach standby");
  stop_wait_a: assert property (stop_c && !start_c && mem_busy
    |=> state_q == DIF_WAIT_WR && !standby)
    else $error("stop during write cycle not held");
  area_latch_a: assert property (state_q == DIF_ACK_DEV
    && $past(state_q) == DIF_DEVSEL |-> area_q == $past(sh_q[DIF_AREA_BIT]))
    else $error("area bit not taken from b3");
  msb_first_a: assert property (state_q == DIF_DEVSEL && !start_c && !stop_c
    && scl_rise && !byte_full |=> sh_q == {$past(sh_q[6:0]), $past(sda_i)})
    else $error("shift order wrong");
  addr_order_a: assert property (state_q == DIF_ACK_HI && !start_c && !stop_c
    && scl_fall |=> state_q == DIF_ADDR_LO && !oe_q)
    else $error("low address byte not next");
  sel_write_a: assert property (state_q == DIF_ACK_DEV && !rw_q && !start_c
    && !stop_c && scl_fall |=> state_q == DIF_ADDR_HI && !oe_q)
    else $error("write select not followed by address");
  ack_release_a: assert property (state_q inside {DIF_ACK_LO, DIF_ACK_WD} && !start_c
    && !stop_c && scl_fall |=> state_q == DIF_WDATA && !oe_q)
    else $error("ack not released after byte");
  nack_end_a: assert property (state_q == DIF_MACK && !start_c && !stop_c
    && scl_rise && sda_i |=> state_q == DIF_IGNORE && !mem_rd)
    else $error("not-acknowledge did not end read");
  wr_pulse_a: assert property (mem_wr |-> state_q == DIF_ACK_WD ##1 !mem_wr)
    else $error("write strobe not single");
  rd_pulse_a: assert property (mem_rd |=> !mem_rd)
    else $error("read strobe not single");
  strobe_excl_a: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");

  // Main scenarios
  write_byte_c: cover property (mem_wr);
  read_byte_c: cover property (state_q == DIF_RDATA && scl_fall && byte_full);
  ignore_c: cover property (state_q == DIF_IGNORE);
  wait_wr_c: cover property (state_q == DIF_WAIT_WR ##1 state_q == DIF_IDLE);
  nack_c: cover property (state_q == DIF_MACK && scl_rise && sda_i);
endmodule

// >>> dif_bus_master.sv
/*
  Two-wire bus master model: start, stop, byte transfer with acknowledge slot.
  Assumes the bench resolves sda_in from all open-drain drivers and a pull-up.
*/
`timescale 1ns/10ps
module dif_bus_master (
  // Clock and resolved data line
  input wire logic clk,
  input wire logic sda_in,
  // Bus lines, sda_drv low pulls the data line
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  // Also a repeated start from scl low
  task automatic start();
    sda_drv <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b1;
    half();
  endtask
  // Data stable while scl high, sampled at end of high phase
  task automatic bit_io(input logic b, output logic s);
    sda_drv <= b;
    half();
    scl <= 1'b1;
    half();
    s = sda_in;
    scl <= 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
    output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_tx, ack_rx);
  endtask
endmodule

// >>> tb_top.sv
/*
  Self-checking bench for the serial slave front end with a byte array model.
  Assumes a pull-up on the data line and one 50 MHz clock.
*/
`timescale 1ns/10ps
module tb_top;
  import dif_pkg::*;
  logic clk, rst_n, scl, sda_m, sda, sda_o, sda_oe, s_lo, s_hi, area, mem_wr, mem_rd;
  logic busy, standby, ackr;
  logic [DIF_MEM_AW-1:0] mem_addr, wr_addr;
  logic [DIF_WORD_AW-1:0] widx;
  logic [7:0] wdata, rx, wr_val;
  logic [7:0] rdata = 8'h00;
  logic [7:0] seq [3] = '{8'hA2, 8'h01, 8'h23};
  int n_errors = 0;
  int checked = 0;
  int n_wr = 0;
  // Wire-AND of both open-drain drivers with pull-up
  assign sda = sda_m & (sda_oe ? sda_o : 1'b1);
  dif_bus_master u_mst (.clk(clk), .sda_in(sda), .scl(scl), .sda_drv(sda_m));
  dif_i2c_slave u_dut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .strap_addr_lo(s_lo), .strap_addr_hi(s_hi), .mem_addr(mem_addr),
    .mem_word_idx(widx), .area_select_bit(area), .mem_wr(mem_wr), .mem_wr_data(wdata),
    .mem_rd(mem_rd), .mem_rd_data(rdata), .mem_busy(busy), .standby(standby));
  // Array model: read data derived from the address
  always @(posedge clk) begin
    if (mem_rd) rdata <= mem_addr[7:0] ^ 8'h5A;
    if (mem_wr) begin
      n_wr <= n_wr + 1;
      wr_addr <= mem_addr;
      wr_val <= wdata;
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    #1;
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
    @(posedge clk);
  endtask
  task automatic put(input logic [7:0] b, input logic ack_exp);
    u_mst.xfer(b, 1'b1, rx, ackr);
    chk(16'(ackr), 16'(ack_exp));
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    s_lo = 1'b1;
    s_hi = 1'b0;
    busy = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(16'(standby), 16'h0001);
    u_mst.start();
    foreach (seq[i]) put(seq[i], 1'b0);
    put(8'hC3, 1'b0);
    chk(16'(n_wr), 16'h0001);
    chk(16'(wr_addr), 16'h0123);
    chk(16'(wr_val), 16'h00C3);
    chk(16'(widx), 16'h0049);
    chk(16'(area), 16'h0000);
    busy <= 1'b1;
    u_mst.stop();
    repeat (6) @(posedge clk);
    chk(16'(standby), 16'h0000);
    busy <= 1'b0;
    repeat (4) @(posedge clk);
    chk(16'(standby), 16'h0001);
    $display("test write done");
    u_mst.start();
    put(8'hA2, 1'b0);
    put(8'h01, 1'b0);
    put(8'h55, 1'b0);
    u_mst.start();
    put(8'hA3, 1'b0);
    u_mst.xfer(8'hFF, 1'b0, rx, ackr);
    chk(16'(rx), 16'h000F);
    u_mst.xfer(8'hFF, 1'b1, rx, ackr);
    chk(16'(rx), 16'h000C);
    u_mst.stop();
    $display("test read done");
    for (int k = 0; k < 4; k++) begin
      s_hi <= k[1];
      s_lo <= k[0];
      u_mst.start();
      put({4'hA, 1'b1, k[1], k[0], 1'b0}, 1'b0);
      chk(16'(area), 16'h0001);
      u_mst.start();
      put({4'hA, 1'b0, ~k[1], ~k[0], 1'b0}, 1'b1);
      put(8'h00, 1'b1);
      u_mst.stop();
    end
    u_mst.start();
    put(8'hB6, 1'b1);
    u_mst.stop();
    $display("test select done");
    u_mst.start();
    fork
      u_mst.xfer(8'hA6, 1'b1, rx, ackr);
      begin
        while (!sda_oe) @(posedge clk);
        rst_n <= 1'b0;
      end
    join
    chk(16'(ackr), 16'h0001);
    repeat (2) @(posedge clk);
    chk(16'(sda_oe), 16'h0000);
    chk(16'(standby), 16'h0001);
    u_mst.start();
    put(8'hA6, 1'b1);
    u_mst.stop();
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    u_mst.start();
    put(8'hA6, 1'b0);
    u_mst.stop();
    $display("test reset done");
    print_verdict();
  end
endmodule
